/* File: hdl/elc_pkg.sv */
// package: constants, register map and types for the link control block
package elc_pkg;

    localparam int CLK_PERIOD_NS   = 40;
    localparam int TX_INIT_NS      = 400;
    localparam int TX_INIT_CYCLES  =
        (TX_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_ALIGN_NS     = 800;
    localparam int RX_ALIGN_CYCLES =
        (RX_ALIGN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 8;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_TX_PKT_CNT = 8'h14;
    localparam logic [ADDR_W-1:0] REG_RX_PKT_CNT = 8'h18;

    localparam int CTRL_W          = 6;
    localparam int CTRL_TX_PERMIT  = 0;
    localparam int CTRL_TX_LF      = 1;
    localparam int CTRL_TX_RF      = 2;
    localparam int CTRL_TX_IDLE    = 3;
    localparam int CTRL_RX_PERMIT  = 4;
    localparam int CTRL_RX_REALIGN = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h10;

    localparam int EV_N          = 5;
    localparam int EV_TX_PKT     = 0;
    localparam int EV_RX_PKT     = 1;
    localparam int EV_RX_ALIGNED = 2;
    localparam int EV_REALIGN    = 3;
    localparam int EV_RX_FAULT   = 4;

    localparam int STAT_W = 6;

    typedef enum logic [2:0] {
        CODE_IDLE,
        CODE_DATA,
        CODE_END,
        CODE_LOCAL_FAULT,
        CODE_REMOTE_FAULT
    } elc_code_e;

    typedef enum logic [1:0] {TX_INIT, TX_IDLE, TX_PKT} elc_tx_state_e;

    typedef enum logic [2:0] {
        RX_RESET, RX_ALIGN, RX_OFF, RX_IDLE, RX_PKT
    } elc_rx_state_e;

endpackage

/* File: hdl/elc_irq_if.sv */
// interface: event, clear and enable signals between core and irq block
`timescale 1ns/1ns
interface elc_irq_if
    import elc_pkg::*;
#(
    parameter int N = EV_N
);
    logic [N-1:0] events;
    logic [N-1:0] clear;
    logic         enable_we;
    logic [N-1:0] enable_wdata;
    logic [N-1:0] status;
    logic [N-1:0] enable;
    logic         irq;

    modport core (output events, clear, enable_we, enable_wdata,
                  input  status, enable, irq);
    modport sink (input  events, clear, enable_we, enable_wdata,
                  output status, enable, irq);
endinterface

/* File: hdl/elc_irq.sv */
// module: sticky event status, enable mask and level interrupt
`timescale 1ns/1ns
module elc_irq
    import elc_pkg::*;
#(
    parameter int N = EV_N
)(
    input  wire logic pclk,
    input  wire logic presetn,
    elc_irq_if.sink   bus
);
    logic [N-1:0] status;
    logic [N-1:0] enable;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            enable <= '0;
        end else begin
            status <= (status & ~bus.clear) | bus.events;
            if (bus.enable_we) begin
                enable <= bus.enable_wdata;
            end
        end
    end

    assign bus.status = status;
    assign bus.enable = enable;
    assign bus.irq    = |(status & enable);
endmodule

/* File: hdl/elc_link_ctrl.sv */
// module: transmit and receive link control with apb registers
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module elc_link_ctrl
    import elc_pkg::*;
#(
    parameter int DATA_W = 64
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              tx_word_valid,
    input  wire logic [DATA_W-1:0] tx_word_data,
    input  wire logic              tx_packet_end_seg0,
    output logic                   tx_word_ready,
    output elc_code_e              tx_link_code,
    output logic [DATA_W-1:0]      tx_link_data,
    output logic                   tx_encoder_init_flag,
    input  elc_code_e              rx_link_code,
    input  wire logic [DATA_W-1:0] rx_link_data,
    input  wire logic              rx_realign_request,
    output logic                   rx_word_valid,
    output logic [DATA_W-1:0]      rx_word_data,
    output logic                   rx_packet_end,
    output logic                   rx_aligned
);
    logic [CTRL_W-1:0] ctrl;
    logic [31:0]       tx_pkt_cnt;
    logic [31:0]       rx_pkt_cnt;
    logic              realign_meta;
    logic              realign_sync;

    elc_irq_if #(.N(EV_N)) irq_bus ();

    elc_irq #(.N(EV_N)) u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (irq_bus.sink)
    );

    // ---------------- apb slave ----------------
    wire apb_setup = psel & ~penable;
    wire apb_acc   = psel & penable;
    wire apb_wr    = apb_acc & pwrite;

    wire sel_ctrl  = (paddr == REG_CTRL);
    wire sel_stat  = (paddr == REG_STATUS);
    wire sel_ists  = (paddr == REG_IRQ_STATUS);
    wire sel_iclr  = (paddr == REG_IRQ_CLEAR);
    wire sel_ien   = (paddr == REG_IRQ_ENABLE);
    wire sel_txcnt = (paddr == REG_TX_PKT_CNT);
    wire sel_rxcnt = (paddr == REG_RX_PKT_CNT);
    wire addr_hit  = sel_ctrl | sel_stat | sel_ists | sel_iclr
                   | sel_ien | sel_txcnt | sel_rxcnt;

    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~addr_hit;

    wire tx_permit  = ctrl[CTRL_TX_PERMIT];
    wire force_lf   = ctrl[CTRL_TX_LF];
    wire force_rf   = ctrl[CTRL_TX_RF];
    wire force_idle = ctrl[CTRL_TX_IDLE];
    wire rx_permit  = ctrl[CTRL_RX_PERMIT];

    // ---------------- transmit encoder ----------------
    elc_tx_state_e    tx_state;
    elc_tx_state_e    next_tx_state;
    logic [CNT_W-1:0] tx_init_cnt;
    elc_code_e        next_tx_code;

    wire tx_forced   = force_lf | force_rf | force_idle;
    wire tx_in_pkt   = (tx_state == TX_PKT);
    wire tx_init_end = (tx_init_cnt == CNT_W'(TX_INIT_CYCLES - 1));

    // forcing stalls the user; a started packet resumes afterwards
    assign tx_word_ready = ~tx_forced
                         & (tx_in_pkt
                         | ((tx_state == TX_IDLE) & tx_permit));

    wire tx_take = tx_word_valid & tx_word_ready;
    wire tx_last = tx_take & tx_packet_end_seg0;

    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            TX_INIT: begin
                if (tx_init_end && !force_lf) begin
                    next_tx_state = TX_IDLE;
                end
            end
            TX_IDLE: begin
                if (force_lf) begin
                    next_tx_state = TX_INIT;
                end else if (tx_take && !tx_packet_end_seg0) begin
                    next_tx_state = TX_PKT;
                end
            end
            TX_PKT: begin
                if (tx_last) begin
                    next_tx_state = TX_IDLE;
                end
            end
            default: next_tx_state = TX_INIT;
        endcase
    end

    always_comb begin
        if (force_lf) begin
            next_tx_code = CODE_LOCAL_FAULT;
        end else if (force_rf) begin
            next_tx_code = CODE_REMOTE_FAULT;
        end else if (force_idle) begin
            next_tx_code = CODE_IDLE;
        end else if (tx_take) begin
            next_tx_code = tx_packet_end_seg0 ? CODE_END : CODE_DATA;
        end else begin
            next_tx_code = CODE_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state    <= TX_INIT;
            tx_init_cnt <= '0;
        end else begin
            tx_state <= next_tx_state;
            if (tx_state != TX_INIT) begin
                tx_init_cnt <= '0;
            end else if (!tx_init_end) begin
                tx_init_cnt <= tx_init_cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_link_code <= CODE_IDLE;
            tx_link_data <= '0;
        end else begin
            tx_link_code <= next_tx_code;
            tx_link_data <= (next_tx_code == CODE_DATA
                             || next_tx_code == CODE_END)
                            ? tx_word_data : '0;
        end
    end

    assign tx_encoder_init_flag = (tx_state == TX_INIT);

    // ---------------- receive decoder ----------------
    elc_rx_state_e    rx_state;
    elc_rx_state_e    next_rx_state;
    logic [CNT_W-1:0] rx_align_cnt;

    // the second flop alone feeds the receive logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            realign_meta <= 1'b0;
            realign_sync <= 1'b0;
        end else begin
            realign_meta <= rx_realign_request;
            realign_sync <= realign_meta;
        end
    end

    wire rx_realign   = realign_sync | ctrl[CTRL_RX_REALIGN];
    wire rx_is_data   = (rx_link_code == CODE_DATA)
                      | (rx_link_code == CODE_END);
    wire rx_is_end    = (rx_link_code == CODE_END);
    wire rx_is_fault  = (rx_link_code == CODE_LOCAL_FAULT)
                      | (rx_link_code == CODE_REMOTE_FAULT);
    wire rx_align_end = (rx_align_cnt == CNT_W'(RX_ALIGN_CYCLES - 1));
    wire rx_run       = (rx_state == RX_IDLE) | (rx_state == RX_PKT)
                      | (rx_state == RX_OFF);

    // new packets start only in idle with permit; a packet in progress
    // runs to its end even after permit falls
    wire rx_deliver = ~rx_realign & rx_is_data
                    & (((rx_state == RX_IDLE) & rx_permit)
                    | (rx_state == RX_PKT));

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            RX_RESET: begin
                next_rx_state = RX_ALIGN;
            end
            RX_ALIGN: begin
                if (rx_align_end) begin
                    next_rx_state = rx_permit ? RX_IDLE : RX_OFF;
                end
            end
            RX_IDLE: begin
                if (!rx_permit) begin
                    next_rx_state = RX_OFF;
                end else if (rx_is_data && !rx_is_end) begin
                    next_rx_state = RX_PKT;
                end
            end
            RX_PKT: begin
                if (rx_is_end || !rx_is_data) begin
                    next_rx_state = rx_permit ? RX_IDLE : RX_OFF;
                end
            end
            RX_OFF: begin
                // resume only between packets
                if (rx_permit && !rx_is_data) begin
                    next_rx_state = RX_IDLE;
                end
            end
            default: next_rx_state = RX_RESET;
        endcase
        if (rx_realign) begin
            next_rx_state = RX_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state     <= RX_RESET;
            rx_align_cnt <= '0;
        end else begin
            rx_state <= next_rx_state;
            if (rx_state != RX_ALIGN) begin
                rx_align_cnt <= '0;
            end else if (!rx_align_end) begin
                rx_align_cnt <= rx_align_cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_word_valid <= 1'b0;
            rx_word_data  <= '0;
            rx_packet_end <= 1'b0;
        end else begin
            rx_word_valid <= rx_deliver;
            rx_word_data  <= rx_deliver ? rx_link_data : '0;
            rx_packet_end <= rx_deliver & rx_is_end;
        end
    end

    assign rx_aligned = rx_run;

    // ---------------- statistics ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pkt_cnt <= '0;
            rx_pkt_cnt <= '0;
        end else begin
            if (tx_last) begin
                tx_pkt_cnt <= tx_pkt_cnt + 32'h00000001;
            end
            if (rx_deliver && rx_is_end) begin
                rx_pkt_cnt <= rx_pkt_cnt + 32'h00000001;
            end
        end
    end

    // ---------------- events ----------------
    logic [EV_N-1:0] ev;
    always_comb begin
        ev                = '0;
        ev[EV_TX_PKT]     = tx_last;
        ev[EV_RX_PKT]     = rx_deliver & rx_is_end;
        ev[EV_RX_ALIGNED] = (rx_state == RX_ALIGN) & rx_align_end
                          & ~rx_realign;
        ev[EV_REALIGN]    = rx_realign & (rx_state != RX_RESET);
        ev[EV_RX_FAULT]   = rx_run & rx_is_fault & ~rx_realign;
    end

    assign irq_bus.events       = ev;
    assign irq_bus.clear        = (apb_wr & sel_iclr)
                                ? pwdata[EV_N-1:0] : '0;
    assign irq_bus.enable_we    = apb_wr & sel_ien;
    assign irq_bus.enable_wdata = pwdata[EV_N-1:0];
    assign irq                  = irq_bus.irq;

    // ---------------- register write and read ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (apb_wr && sel_ctrl) begin
            ctrl <= pwdata[CTRL_W-1:0];
        end
    end

    wire [STAT_W-1:0] live_status = {
        realign_sync,
        rx_state == RX_OFF,
        rx_state == RX_PKT,
        rx_run,
        tx_in_pkt,
        tx_encoder_init_flag
    };

    wire [31:0] rd_mux =
        sel_ctrl  ? {{(32-CTRL_W){1'b0}}, ctrl} :
        sel_stat  ? {{(32-STAT_W){1'b0}}, live_status} :
        sel_ists  ? {{(32-EV_N){1'b0}}, irq_bus.status} :
        sel_ien   ? {{(32-EV_N){1'b0}}, irq_bus.enable} :
        sel_txcnt ? tx_pkt_cnt :
        sel_rxcnt ? rx_pkt_cnt :
                    32'h00000000;

    // read data is caught in the setup cycle and held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end
endmodule

/* File: bench/elc_link_ctrl_asserts.sv */
// checker: transmit and receive link control properties at the top ports
`timescale 1ns/1ns
module elc_link_ctrl_asserts
    import elc_pkg::*;
#(
    parameter int DATA_W = 64
)(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              tx_word_valid,
    input wire logic [DATA_W-1:0] tx_word_data,
    input wire logic              tx_packet_end_seg0,
    input wire logic              tx_word_ready,
    input elc_code_e              tx_link_code,
    input wire logic [DATA_W-1:0] tx_link_data,
    input wire logic              tx_encoder_init_flag,
    input wire logic              rx_realign_request,
    input wire logic              rx_word_valid,
    input wire logic              rx_packet_end,
    input wire logic              rx_aligned
);
    logic [CTRL_W-1:0] ctrl;
    logic              tx_busy;
    wire               ctrl_wr = psel && penable && pwrite
                                 && paddr == REG_CTRL;
    wire               taken   = tx_word_valid && tx_word_ready;

    // shadow of the control register and of an open transmit packet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            tx_busy <= 1'b0;
        end else begin
            if (ctrl_wr)
                ctrl <= pwdata[CTRL_W-1:0];
            if (taken)
                tx_busy <= !tx_packet_end_seg0;
        end
    end

    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_lf_only: assert property (
        ctrl[1] |=> tx_link_code == CODE_LOCAL_FAULT)
        else $error("local fault force not on link");
    a_rf_only: assert property (
        ctrl[2] && !ctrl[1] |=> tx_link_code == CODE_REMOTE_FAULT)
        else $error("remote fault force not on link");
    a_idle_force: assert property (
        ctrl[3] && ctrl[2:1] == 2'b00 |=> tx_link_code == CODE_IDLE)
        else $error("idle force not on link");
    a_force_stall: assert property (
        |ctrl[3:1] |-> !tx_word_ready)
        else $error("word accepted while forced");
    a_permit_idle: assert property (
        !ctrl[0] && !tx_busy && ctrl[3:1] == 3'b000
        |=> tx_link_code == CODE_IDLE)
        else $error("traffic without permit");
    a_finish_pkt: assert property (
        tx_busy && tx_word_valid && ctrl[3:1] == 3'b000 |-> tx_word_ready)
        else $error("open packet stalled");
    a_word_link: assert property (
        taken |=> tx_link_data == $past(tx_word_data) && tx_link_code ==
        ($past(tx_packet_end_seg0) ? CODE_END : CODE_DATA))
        else $error("taken word not on link");
    a_init_hold: assert property (
        tx_encoder_init_flag |-> !tx_word_ready)
        else $error("word accepted during encoder init");
    a_rx_off: assert property (
        !ctrl[4] && !(rx_word_valid && !rx_packet_end) |=> !rx_word_valid)
        else $error("delivery while reception off");
    a_realign_hold: assert property (
        rx_realign_request [*3] |=> !rx_aligned)
        else $error("realign request ignored");
    a_pulse_seen: assert property (
        $rose(rx_realign_request) && rx_aligned |-> ##[1:4] !rx_aligned)
        else $error("short realign pulse missed");

    c_tx_end: cover property (taken && tx_packet_end_seg0);
    c_rx_end: cover property (rx_word_valid && rx_packet_end);
    c_realign: cover property ($fell(rx_aligned));
endmodule

bind elc_link_ctrl elc_link_ctrl_asserts #(.DATA_W(DATA_W)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .tx_word_valid, .tx_word_data, .tx_packet_end_seg0, .tx_word_ready,
    .tx_link_code, .tx_link_data, .tx_encoder_init_flag,
    .rx_realign_request, .rx_word_valid, .rx_packet_end, .rx_aligned);

/* File: bench/elc_partner.sv */
// link partner model: sends packets and tallies the codes it receives
`timescale 1ns/1ns
module elc_partner
    import elc_pkg::*;
(
    input  wire logic   pclk,
    input  elc_code_e   tx_link_code,
    output elc_code_e   rx_link_code,
    output logic [63:0] rx_link_data
);
    int seen [5];
    initial begin
        rx_link_code = CODE_IDLE;
        rx_link_data = 64'h0;
    end
    always @(posedge pclk)
        seen[tx_link_code]++;
    // idle between frames; the data line flips so no stale word survives
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_link_code <= (i == n - 1) ? CODE_END : CODE_DATA;
            rx_link_data <= 64'hA500 + 64'(i);
        end
        @(posedge pclk);
        rx_link_code <= CODE_IDLE;
        rx_link_data <= ~rx_link_data;
    endtask
    // remote fault words for n cycles, then idle again
    task automatic fault(input int n);
        repeat (n) begin
            @(posedge pclk);
            rx_link_code <= CODE_REMOTE_FAULT;
        end
        @(posedge pclk);
        rx_link_code <= CODE_IDLE;
    endtask
endmodule

/* File: bench/elc_link_ctrl_tb.sv */
// testbench: registers, user stream, link partner and realign pin
`timescale 1ns/1ns
module elc_link_ctrl_tb;
    import elc_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, irq, tx_word_valid, tx_word_ready;
    logic              tx_packet_end_seg0, tx_encoder_init_flag;
    logic [63:0]       tx_word_data, tx_link_data, rx_link_data, rx_word_data;
    logic              rx_realign_request, rx_word_valid;
    logic              rx_packet_end, rx_aligned;
    elc_code_e         tx_link_code, rx_link_code;
    int                fail_count, total_checks, n_rx, n_end;
    logic [63:0]       last_rx;

    elc_link_ctrl DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .tx_word_valid, .tx_word_data,
        .tx_packet_end_seg0, .tx_word_ready, .tx_link_code, .tx_link_data,
        .tx_encoder_init_flag, .rx_link_code, .rx_link_data,
        .rx_realign_request, .rx_word_valid, .rx_word_data, .rx_packet_end,
        .rx_aligned);
    elc_partner peer (.pclk, .tx_link_code, .rx_link_code, .rx_link_data);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (rx_word_valid === 1'b1) begin
            n_rx++;
            last_rx = rx_word_data;
        end
        if (rx_word_valid === 1'b1 && rx_packet_end === 1'b1)
            n_end++;
    end

    task automatic conclude();
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("wait_level", s, v);
        if (s !== v)
            conclude();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            fail_count++;
            conclude();
        end
        @(posedge pclk);
    endtask
    task automatic tx_pkt(input int n);
        int i;
        int k;
        i = 0;
        k = 0;
        @(posedge pclk);
        tx_word_valid <= 1'b1;
        tx_word_data <= 64'h100;
        tx_packet_end_seg0 <= (n == 1);
        while (i < n && k < 50) begin
            @(posedge pclk);
            k++;
            if (tx_word_ready === 1'b1) begin
                i++;
                tx_word_data <= 64'h100 + 64'(i);
                tx_packet_end_seg0 <= (i == n - 1);
            end
        end
        tx_word_valid <= 1'b0;
        chk("tx_taken", i, n);
    endtask

    task automatic t_reset();
        chk("init_flag", tx_encoder_init_flag, 1);
        apb(0, REG_CTRL, 0);
        chk("ctrl_reset", rd, CTRL_RESET);
        apb(1, REG_CTRL, 32'h14);
        wait_sig(rx_aligned, 1'b1, 40);
        chk("rf_held", tx_link_code, CODE_REMOTE_FAULT);
        chk("init_flag", tx_encoder_init_flag, 0);
        apb(0, REG_STATUS, 0);
        chk("status", rd, 32'h04);
    endtask
    task automatic t_tx();
        int d;
        int e;
        d = peer.seen[CODE_DATA];
        e = peer.seen[CODE_END];
        apb(1, REG_CTRL, 32'h11);
        tx_pkt(3);
        repeat (2) @(posedge pclk);
        chk("tx_data", peer.seen[CODE_DATA] - d, 2);
        chk("tx_end", peer.seen[CODE_END] - e, 1);
        chk("irq_masked", irq, 0);
        apb(1, REG_IRQ_ENABLE, 1);
        chk("irq_on", irq, 1);
        apb(1, REG_IRQ_CLEAR, 1);
        chk("irq_clear", irq, 0);
        apb(0, REG_TX_PKT_CNT, 0);
        chk("tx_count", rd, 1);
        apb(0, 8'h40, 0);
        chk("unmapped_err", err, 1);
        chk("unmapped_data", rd, 0);
    endtask
    task automatic t_drop();
        int e;
        e = peer.seen[CODE_END];
        fork
            tx_pkt(5);
            apb(1, REG_CTRL, 32'h10);
        join
        repeat (2) @(posedge pclk);
        chk("tx_end_drop", peer.seen[CODE_END] - e, 1);
        tx_word_valid <= 1'b1;
        repeat (6) begin
            @(posedge pclk);
            chk("ready_off", tx_word_ready, 0);
            chk("link_idle", tx_link_code, CODE_IDLE);
        end
        tx_word_valid <= 1'b0;
    endtask
    task automatic t_force();
        logic [5:0] w [5] = '{6'h13, 6'h15, 6'h19, 6'h1F, 6'h1D};
        elc_code_e  x [5] = '{CODE_LOCAL_FAULT, CODE_REMOTE_FAULT, CODE_IDLE,
                              CODE_LOCAL_FAULT, CODE_REMOTE_FAULT};
        fork
            peer.fault(3);
            apb(1, REG_CTRL, 32'h18);
        join
        apb(0, REG_IRQ_STATUS, 0);
        chk("fault_event", rd[EV_RX_FAULT], 1);
        chk("fault_idle", tx_link_code, CODE_IDLE);
        tx_word_valid <= 1'b1;
        foreach (w[i]) begin
            apb(1, REG_CTRL, {26'h0, w[i]});
            repeat (3) begin
                @(posedge pclk);
                chk("force_code", tx_link_code, x[i]);
                chk("force_ready", tx_word_ready, 0);
            end
        end
        tx_word_valid <= 1'b0;
        apb(1, REG_CTRL, 32'h10);
    endtask
    task automatic t_rx();
        int v;
        int e;
        v = n_rx;
        e = n_end;
        fork
            peer.send(6);
            apb(1, REG_CTRL, 32'h00);
        join
        repeat (3) @(posedge pclk);
        chk("rx_finish", n_rx - v, 6);
        chk("rx_end", n_end - e, 1);
        peer.send(2);
        repeat (3) @(posedge pclk);
        chk("rx_off", n_rx - v, 6);
        apb(0, REG_RX_PKT_CNT, 0);
        chk("rx_count", rd, 1);
        apb(0, REG_STATUS, 0);
        chk("status_off", rd, 32'h14);
        apb(1, REG_CTRL, 32'h10);
        peer.send(1);
        repeat (3) @(posedge pclk);
        chk("rx_back", n_end - e, 2);
        chk("rx_data", last_rx, 64'hA500);
    endtask
    task automatic t_realign();
        int v;
        @(posedge pclk);
        rx_realign_request <= 1'b1;
        @(posedge pclk);
        rx_realign_request <= 1'b0;
        wait_sig(rx_aligned, 1'b0, 6);
        v = n_rx;
        peer.send(2);
        chk("rx_in_reset", n_rx - v, 0);
        wait_sig(rx_aligned, 1'b1, 40);
        peer.send(1);
        repeat (3) @(posedge pclk);
        chk("rx_realigned", n_rx - v, 1);
        rx_realign_request <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(0, REG_STATUS, 0);
        chk("status_pin", rd, 32'h20);
        rx_realign_request <= 1'b0;
        wait_sig(rx_aligned, 1'b1, 40);
        apb(1, REG_CTRL, 32'h30);
        wait_sig(rx_aligned, 1'b0, 4);
        apb(1, REG_CTRL, 32'h10);
        wait_sig(rx_aligned, 1'b1, 40);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        tx_word_valid = 1'b0;
        tx_word_data = '0;
        tx_packet_end_seg0 = 1'b0;
        rx_realign_request = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx();
        t_drop();
        t_force();
        t_rx();
        t_realign();
        conclude();
    end
endmodule
